// >>> rtl/link_ctrl_status_pm_cap_regs.sv
// Overview of operation
// - clock-mode bit 6: writable, reset zero
// - clock-mode bit selects reported exit latency
// - latency 110b when 0, 010b when 1
// - power control bits 1:0 writable, reset zero
// - power control only permits standby, no action
// - other link control bits read zero
// - status bits 9:4 give trained lane count
// - status bits 3:0 always read 0001b
// - status read-only: 0041h x4, 0081h x8
// - capability identifier reads 01h
// - capability next pointer reads zero
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_status_pm_cap_regs
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration request, one dword per access
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  // configuration completion
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // link training result
  input wire logic [5:0] trained_lane_count_i,
  // to link logic
  output logic shared_refclk_select_o,
  output logic [1:0] link_power_state_control_o,
  output logic [2:0] standby_exit_latency_o,
  output logic standby_entry_allowed_o
);

  link_regs_if regs ();

  logic hit_link;
  logic hit_pmcap;
  logic [31:0] next_rdata;
  logic [15:0] prev_ctrl;

  // dword decode, low address bits ignored
  always_comb
  begin
    hit_link = 1'b0;
    hit_pmcap = 1'b0;
    if (cfg_addr_i[7:2] ==
        link_regs_pkg::LINK_CONTROL_OFS[7:2])
      hit_link = 1'b1;
    else if (cfg_addr_i[7:2] ==
             link_regs_pkg::POWER_CAPABILITY_IDENTIFIER_OFS[7:2])
      hit_pmcap = 1'b1;
  end

  // only the link control half of the dword accepts data
  assign regs.wr_ctrl = cfg_req_i && cfg_we_i && hit_link;
  assign regs.wr_be = cfg_be_i[1:0];
  assign regs.wr_data = cfg_wdata_i[15:0];
  assign regs.lane_code = trained_lane_count_i;

  link_control_reg u_ctrl
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bus(regs.ctrl)
  );

  link_status_reg u_stat
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .bus(regs.stat)
  );

  // read data; unmapped dwords and the rest of the pm word read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_link)
      next_rdata = {regs.status_value, regs.ctrl_value};
    else if (hit_pmcap)
      next_rdata = {16'h0000, link_regs_pkg::CAPABILITY_LIST_LINK,
        link_regs_pkg::CAPABILITY_IDENTIFIER};
  end

  // every request, read or write, completes one cycle later
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_ack_o <= 1'b0;
    else
      cfg_ack_o <= cfg_req_i;
  end

  // writes return zero data so a stale read never leaks out
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_rdata_o <= 32'h0000_0000;
    else if (cfg_req_i && !cfg_we_i)
      cfg_rdata_o <= next_rdata;
    else
      cfg_rdata_o <= 32'h0000_0000;
  end

  // registered copies of the control fields toward the link logic;
  // one cycle behind the register, matching the read path latency
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shared_refclk_select_o <= 1'b0;
      link_power_state_control_o <= link_regs_pkg::POWER_DISABLED;
      standby_exit_latency_o <= link_regs_pkg::EXIT_LATENCY_ASYNC;
    end
    else
    begin
      shared_refclk_select_o <=
        regs.ctrl_value[link_regs_pkg::SHARED_REFCLK_POS];
      link_power_state_control_o <= regs.ctrl_value[1:0];
      standby_exit_latency_o <= regs.exit_latency;
    end
  end

  // a permit only; this function never enters standby on its own
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      standby_entry_allowed_o <= 1'b0;
    else
      standby_entry_allowed_o <=
        regs.ctrl_value[1:0] == link_regs_pkg::POWER_STANDBY ||
        regs.ctrl_value[1:0] == link_regs_pkg::POWER_STANDBY_DEEP;
  end

  // helper: last control value, for write checks
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prev_ctrl <= link_regs_pkg::LINK_CONTROL_RESET;
    else
      prev_ctrl <= regs.ctrl_value;
  end

  // helper: kind of request answered in this cycle
  logic read_link_q;
  logic read_pmcap_q;
  logic read_other_q;
  logic write_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      read_link_q <= 1'b0;
      read_pmcap_q <= 1'b0;
      read_other_q <= 1'b0;
      write_q <= 1'b0;
    end
    else
    begin
      read_link_q <= cfg_req_i && !cfg_we_i && hit_link;
      read_pmcap_q <= cfg_req_i && !cfg_we_i && hit_pmcap;
      read_other_q <= cfg_req_i && !cfg_we_i && !hit_link && !hit_pmcap;
      write_q <= cfg_req_i && cfg_we_i;
    end
  end

  AST_CLOCK_MODE_WRITE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && cfg_we_i && hit_link && cfg_be_i[0] |=>
    regs.ctrl_value[link_regs_pkg::SHARED_REFCLK_POS] ==
    $past(cfg_wdata_i[link_regs_pkg::SHARED_REFCLK_POS]))
    else $error("clock-mode bit did not take written value");

  AST_LATENCY_OUT: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && cfg_we_i && hit_link && cfg_be_i[0] |=> ##1
    standby_exit_latency_o ==
    ($past(cfg_wdata_i[link_regs_pkg::SHARED_REFCLK_POS], 2) ?
    link_regs_pkg::EXIT_LATENCY_SHARED : link_regs_pkg::EXIT_LATENCY_ASYNC))
    else $error("exit latency output wrong after clock-mode write");

  AST_POWER_WRITE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && cfg_we_i && hit_link && cfg_be_i[0] |=>
    regs.ctrl_value[1:0] == $past(cfg_wdata_i[1:0]))
    else $error("power control field did not take written value");

  AST_PERMIT_ONLY: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    standby_entry_allowed_o ==
    ($past(regs.ctrl_value[1:0]) == link_regs_pkg::POWER_STANDBY ||
    $past(regs.ctrl_value[1:0]) == link_regs_pkg::POWER_STANDBY_DEEP))
    else $error("standby permit does not follow power control");

  AST_PERMIT_RESERVED: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    regs.ctrl_value[1:0] == link_regs_pkg::POWER_RESERVED |=>
    !standby_entry_allowed_o)
    else $error("reserved power control code gave a standby permit");

  AST_PERMIT_DISABLED: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    regs.ctrl_value[1:0] == link_regs_pkg::POWER_DISABLED |=>
    !standby_entry_allowed_o)
    else $error("disabled power control gave a standby permit");

  AST_RESERVED_ZERO: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_ack_o && $past(cfg_req_i && !cfg_we_i && hit_link) |->
    (cfg_rdata_o & 32'h0000_ffbc) == 32'h0000_0000)
    else $error("reserved link control bits read nonzero");

  AST_LINK_READ_CTRL: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    read_link_q |->
    cfg_ack_o && cfg_rdata_o[15:0] == prev_ctrl)
    else $error("link control read value wrong");

  AST_STATUS_READ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && !cfg_we_i && hit_link |=>
    cfg_rdata_o[31:16] == {6'h00, $past(regs.status_value[9:4]), 4'h1})
    else $error("link status read value wrong");

  AST_LANE_FOLLOWS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    trained_lane_count_i == link_regs_pkg::LANES_X1 ||
    trained_lane_count_i == link_regs_pkg::LANES_X4 ||
    trained_lane_count_i == link_regs_pkg::LANES_X8 |=>
    regs.status_value[9:4] == $past(trained_lane_count_i))
    else $error("lane count in status does not follow training");

  AST_LANE_HOLDS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    trained_lane_count_i != link_regs_pkg::LANES_X1 &&
    trained_lane_count_i != link_regs_pkg::LANES_X4 &&
    trained_lane_count_i != link_regs_pkg::LANES_X8 |=>
    $stable(regs.status_value))
    else $error("undefined lane code changed the status");

  AST_CAP_READ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && !cfg_we_i && hit_pmcap |=>
    cfg_ack_o && cfg_rdata_o == 32'h0000_0001)
    else $error("capability header read value wrong");

  AST_PMCAP_UPPER_ZERO: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    read_pmcap_q |->
    cfg_rdata_o[31:16] == 16'h0000)
    else $error("upper half of capability dword read nonzero");

  AST_RO_WRITE_KEEPS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i && cfg_we_i && !(hit_link && cfg_be_i[0]) |=>
    cfg_ack_o && regs.ctrl_value == prev_ctrl)
    else $error("write to read-only space changed link control");

  AST_ACK_NEXT: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    cfg_req_i |=>
    cfg_ack_o)
    else $error("request not completed in the next cycle");

  AST_ACK_ONLY_ON_REQ: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !cfg_req_i |=>
    !cfg_ack_o)
    else $error("completion without a request");

  AST_WRITE_RDATA_ZERO: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    write_q |->
    cfg_rdata_o == 32'h0000_0000)
    else $error("write completion carried read data");

  AST_OTHER_READ_ZERO: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    read_other_q |->
    cfg_rdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  AST_REFCLK_OUT: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    shared_refclk_select_o ==
    $past(regs.ctrl_value[link_regs_pkg::SHARED_REFCLK_POS]))
    else $error("clock-mode output does not trail the register");

  AST_POWER_OUT: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    link_power_state_control_o ==
    $past(regs.ctrl_value[1:0]))
    else $error("power control output does not trail the register");

  AST_LATENCY_CODE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    standby_exit_latency_o == (shared_refclk_select_o ?
    link_regs_pkg::EXIT_LATENCY_SHARED : link_regs_pkg::EXIT_LATENCY_ASYNC))
    else $error("exit latency output disagrees with clock-mode output");

endmodule : link_ctrl_status_pm_cap_regs
`default_nettype wire

// >>> rtl/link_regs_pkg.sv
`default_nettype none
package link_regs_pkg;

  // configuration space, byte addresses
  localparam logic [7:0] LINK_CONTROL_OFS = 8'h54;
  localparam logic [7:0] LINK_STATE_REPORT_OFS = 8'h56;
  localparam logic [7:0] POWER_CAPABILITY_IDENTIFIER_OFS = 8'h6c;
  localparam logic [7:0] POWER_CAPABILITY_LINK_OFS = 8'h6d;
  localparam int DWORD_LSB = 2;

  // link_control fields
  localparam int SHARED_REFCLK_POS = 6;
  localparam int LINK_POWER_LSB = 0;
  localparam int LINK_POWER_W = 2;
  localparam logic [15:0] LINK_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] LINK_CONTROL_WMASK = 16'h0043;

  // link power state control encodings
  localparam logic [1:0] POWER_DISABLED = 2'h0;
  localparam logic [1:0] POWER_STANDBY = 2'h1;
  localparam logic [1:0] POWER_RESERVED = 2'h2;
  localparam logic [1:0] POWER_STANDBY_DEEP = 2'h3;

  // standby exit latency codes for the link capability word
  localparam logic [2:0] EXIT_LATENCY_ASYNC = 3'h6;
  localparam logic [2:0] EXIT_LATENCY_SHARED = 3'h2;

  // link_state_report fields
  localparam int LANE_LSB = 4;
  localparam int LANE_W = 6;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 4;
  localparam logic [3:0] SIGNALLING_RATE_CODE = 4'h1;
  localparam logic [5:0] LANES_X1 = 6'h00;
  localparam logic [5:0] LANES_X4 = 6'h04;
  localparam logic [5:0] LANES_X8 = 6'h08;
  localparam logic [15:0] LINK_STATE_REPORT_RESET = 16'h0001;

  // power management capability header
  localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h01;
  localparam logic [7:0] CAPABILITY_LIST_LINK = 8'h00;

endpackage : link_regs_pkg
`default_nettype wire

// >>> rtl/link_regs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface link_regs_if;
  logic wr_ctrl;
  logic [1:0] wr_be;
  logic [15:0] wr_data;
  logic [5:0] lane_code;
  logic [15:0] ctrl_value;
  logic [2:0] exit_latency;
  logic [15:0] status_value;

  modport top
  (
    output wr_ctrl,
    output wr_be,
    output wr_data,
    output lane_code,
    input ctrl_value,
    input exit_latency,
    input status_value
  );
  modport ctrl
  (
    input wr_ctrl,
    input wr_be,
    input wr_data,
    output ctrl_value,
    output exit_latency
  );
  modport stat
  (
    input lane_code,
    output status_value
  );
endinterface : link_regs_if
`default_nettype wire

// >>> rtl/link_control_reg.sv
`timescale 1ns/1ps
`default_nettype none
module link_control_reg
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register traffic
  link_regs_if.ctrl bus
);

  logic shared_refclk;
  logic [1:0] power_ctrl;
  logic [2:0] latency;

  // only bits 6 and 1:0 hold state; the rest are tied off
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shared_refclk <= link_regs_pkg::LINK_CONTROL_RESET[
        link_regs_pkg::SHARED_REFCLK_POS];
      power_ctrl <= link_regs_pkg::LINK_CONTROL_RESET[1:0];
    end
    else if (bus.wr_ctrl && bus.wr_be[0])
    begin
      shared_refclk <= bus.wr_data[link_regs_pkg::SHARED_REFCLK_POS];
      power_ctrl <= bus.wr_data[1:0];
    end
  end

  // latency flop updated on the same edge as the clock-mode bit
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      latency <= link_regs_pkg::EXIT_LATENCY_ASYNC;
    else if (bus.wr_ctrl && bus.wr_be[0])
      latency <= bus.wr_data[link_regs_pkg::SHARED_REFCLK_POS] ?
        link_regs_pkg::EXIT_LATENCY_SHARED :
        link_regs_pkg::EXIT_LATENCY_ASYNC;
  end

  assign bus.ctrl_value = {9'h000, shared_refclk, 2'h0, 1'b0, 1'b0,
    power_ctrl};
  assign bus.exit_latency = latency;

  AST_LATENCY_TRACKS: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    latency == (shared_refclk ? link_regs_pkg::EXIT_LATENCY_SHARED :
    link_regs_pkg::EXIT_LATENCY_ASYNC))
    else $error("exit latency out of step with clock mode");

  AST_HIGH_BYTE_IGNORED: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    bus.wr_ctrl && !bus.wr_be[0] |=> $stable(bus.ctrl_value))
    else $error("link control changed without low byte enable");

endmodule : link_control_reg
`default_nettype wire

// >>> rtl/link_status_reg.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_reg
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // lane code in, report out
  link_regs_if.stat bus
);

  logic [5:0] lanes;

  // an undefined width code keeps the last good one
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      lanes <= link_regs_pkg::LINK_STATE_REPORT_RESET[9:4];
    else if (bus.lane_code == link_regs_pkg::LANES_X1 ||
             bus.lane_code == link_regs_pkg::LANES_X4 ||
             bus.lane_code == link_regs_pkg::LANES_X8)
      lanes <= bus.lane_code;
  end

  assign bus.status_value = {6'h00, lanes,
    link_regs_pkg::SIGNALLING_RATE_CODE};

  AST_LANES_LEGAL: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    lanes == link_regs_pkg::LANES_X1 || lanes == link_regs_pkg::LANES_X4 ||
    lanes == link_regs_pkg::LANES_X8)
    else $error("lane width code is not a defined encoding");

endmodule : link_status_reg
`default_nettype wire

// >>> dv/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
(
  // clock
  input wire logic clk_i,
  // width picked by the bench
  input wire logic [1:0] width_sel_i,
  // training outcome
  output logic [5:0] trained_lane_count_o
);
  // the last choice offers a width the function does not define
  always_ff @(posedge clk_i)
  begin
    case (width_sel_i)
      2'h0: trained_lane_count_o <= link_regs_pkg::LANES_X1;
      2'h1: trained_lane_count_o <= link_regs_pkg::LANES_X4;
      2'h2: trained_lane_count_o <= link_regs_pkg::LANES_X8;
      default: trained_lane_count_o <= 6'h02;
    endcase
  end
endmodule : link_partner_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i;
  logic resetn_i;
  logic cfg_req_i;
  logic cfg_we_i;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i;
  logic [31:0] cfg_wdata_i;
  logic cfg_ack_o;
  logic [31:0] cfg_rdata_o;
  logic [5:0] lane;
  logic [1:0] width_sel;
  logic refclk;
  logic [1:0] pwr;
  logic [2:0] lat;
  logic allow;
  logic [31:0] rd;
  logic [31:0] d;
  logic [15:0] ctrl_m;
  logic [5:0] lane_m;
  int lanes[4] = '{0, 4, 8, 8};
  int err_count;
  int checked;

  link_partner_model link_partner_model_i
  (
    .clk_i(clk_i), .width_sel_i(width_sel), .trained_lane_count_o(lane)
  );
  link_ctrl_status_pm_cap_regs link_ctrl_status_pm_cap_regs_i
  (
    .clk_i(clk_i), .resetn_i(resetn_i), .cfg_req_i(cfg_req_i),
    .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o),
    .cfg_rdata_o(cfg_rdata_o), .trained_lane_count_i(lane),
    .shared_refclk_select_o(refclk), .link_power_state_control_o(pwr),
    .standby_exit_latency_o(lat), .standby_entry_allowed_o(allow)
  );

  task automatic close_out();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one request, completion awaited under a bound
  task automatic cfg(input logic we, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_i);
    cfg_req_i <= 1'b1;
    cfg_we_i <= we;
    cfg_addr_i <= a;
    cfg_be_i <= be;
    cfg_wdata_i <= wd;
    @(posedge clk_i);
    cfg_req_i <= 1'b0;
    @(negedge clk_i);
    while (cfg_ack_o !== 1'b1 && n < 4)
    begin
      @(negedge clk_i);
      n++;
    end
    if (cfg_ack_o !== 1'b1)
    begin
      err_count++;
      close_out();
    end
    rd = cfg_rdata_o;
  endtask : cfg

  function automatic logic [31:0] exp54();
    return {6'h0, lane_m, 4'h1, ctrl_m};
  endfunction : exp54

  // link side outputs trail the register by one cycle
  task automatic chk_out();
    @(negedge clk_i);
    check({25'h0, refclk, pwr, lat, allow},
      {25'h0, ctrl_m[6], ctrl_m[1:0], ctrl_m[6] ? 3'h2 : 3'h6, ctrl_m[0]});
  endtask : chk_out

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial
  begin
    void'($urandom(32'h82ede289));
    resetn_i = 1'b0;
    cfg_req_i = 1'b0;
    cfg_we_i = 1'b0;
    cfg_addr_i = 8'h00;
    cfg_be_i = 4'h0;
    cfg_wdata_i = 32'h0;
    width_sel = 2'h0;
    ctrl_m = 16'h0000;
    lane_m = 6'h00;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    cfg(1'b0, 8'h54, 4'hf, 32'h0);
    check(rd, exp54());
    chk_out();
    for (int i = 0; i < 8; i++)
    begin
      d = $urandom;
      d[6] = i[2];
      d[1:0] = i[1:0];
      cfg(1'b1, 8'h54, 4'h1, d);
      check(rd, 32'h0);
      ctrl_m = d[15:0] & 16'h0043;
      chk_out();
      cfg(1'b0, 8'h54, 4'hf, 32'h0);
      check(rd, exp54());
    end
    cfg(1'b1, 8'h54, 4'he, $urandom);
    cfg(1'b0, 8'h54, 4'hf, 32'h0);
    check(rd, exp54());
    cfg(1'b1, 8'h6c, 4'hf, $urandom);
    cfg(1'b0, 8'h6d, 4'hf, 32'h0);
    check(rd, 32'h0000_0001);
    cfg(1'b0, 8'h40, 4'hf, 32'h0);
    check(rd, 32'h0);
    // the last width code is undefined, so x8 must stay
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      width_sel <= k[1:0];
      lane_m = 6'(lanes[k]);
      repeat (3) @(posedge clk_i);
      cfg(1'b0, 8'h56, 4'hf, 32'h0);
      check(rd, exp54());
    end
    cfg(1'b1, 8'h56, 4'hc, $urandom);
    cfg(1'b0, 8'h54, 4'hf, 32'h0);
    check(rd, exp54());
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    ctrl_m = 16'h0000;
    lane_m = 6'h00;
    chk_out();
    cfg(1'b0, 8'h54, 4'hf, 32'h0);
    check(rd, exp54());
    close_out();
  end
endmodule : testbench
`default_nettype wire
